// ===== inc/gcs_pkg.sv
/*
 * Shared definitions of the rate sensor control and status register bank:
 * register offsets, bit positions, reset values, path and mode codes, and
 * the structs that carry the host access, the samples and the settings.
 * Assumes one clock domain shared by the serial front end and the core.
 */
package gcs_pkg;

	// Register offsets (7-bit serial addresses)
	localparam logic [6:0] ADDR_IRQ_ROUTING   = 7'h22;
	localparam logic [6:0] ADDR_RANGE_FORMAT  = 7'h23;
	localparam logic [6:0] ADDR_FILTER_FIFO   = 7'h24;
	localparam logic [6:0] ADDR_IRQ_REFERENCE = 7'h25;
	localparam logic [6:0] ADDR_TEMPERATURE   = 7'h26;
	localparam logic [6:0] ADDR_SAMPLE_STATUS = 7'h27;
	localparam logic [6:0] ADDR_RATE_X_LOW    = 7'h28;
	localparam logic [6:0] ADDR_RATE_X_HIGH   = 7'h29;
	localparam logic [6:0] ADDR_RATE_Y_LOW    = 7'h2A;
	localparam logic [6:0] ADDR_RATE_Y_HIGH   = 7'h2B;
	localparam logic [6:0] ADDR_RATE_Z_LOW    = 7'h2C;
	localparam logic [6:0] ADDR_RATE_Z_HIGH   = 7'h2D;
	localparam logic [6:0] ADDR_BUFFER_MODE   = 7'h2E;

	// Interrupt routing bits
	localparam int BIT_IRQ_TO_PIN_ONE    = 7;
	localparam int BIT_RELOAD_TO_PIN_ONE = 6;
	localparam int BIT_PIN_ONE_LOW       = 5;
	localparam int BIT_OPEN_DRAIN        = 4;
	localparam int BIT_READY_TO_TWO      = 3;
	localparam int BIT_WATERMARK_TO_TWO  = 2;
	localparam int BIT_OVERFLOW_TO_TWO   = 1;
	localparam int BIT_VACANT_TO_TWO     = 0;

	// Range and format bits
	localparam int BIT_BYTE_ORDER = 6;
	localparam int LSB_RANGE      = 4;
	localparam int LSB_SELFTEST   = 1;
	localparam int BIT_SPI_WIRES  = 0;

	// Filter, buffer and reload bits
	localparam int BIT_RELOAD    = 7;
	localparam int BIT_FIFO_ON   = 6;
	localparam int BIT_HIGHPASS  = 4;
	localparam int LSB_IRQ_PATH  = 2;
	localparam int LSB_OUT_PATH  = 0;

	// Buffer mode register fields
	localparam int LSB_BUFFER_MODE = 5;
	localparam int LSB_WATERMARK   = 0;

	// Status register bits
	localparam int BIT_ALL_OVR   = 7;
	localparam int LSB_AXIS_OVR  = 4;
	localparam int BIT_ALL_READY = 3;
	localparam int LSB_AXIS_RDY  = 0;

	// Writable bit masks; everything else stays zero
	localparam logic [7:0] MASK_IRQ_ROUTING  = 8'hFF;
	localparam logic [7:0] MASK_RANGE_FORMAT = 8'h77;
	localparam logic [7:0] MASK_FILTER_FIFO  = 8'h5F;
	localparam logic [7:0] MASK_BUFFER_MODE  = 8'hFF;

	// Reset values
	localparam logic [7:0]  RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// Full scale codes
	localparam logic [1:0] RANGE_245  = 2'h0;
	localparam logic [1:0] RANGE_500  = 2'h1;
	localparam logic [1:0] RANGE_2000 = 2'h2;

	// Self-test codes
	localparam logic [1:0] SELFTEST_OFF = 2'h0;
	localparam logic [1:0] SELFTEST_POS = 2'h1;
	localparam logic [1:0] SELFTEST_NEG = 2'h3;

	// Buffer mode codes
	localparam logic [2:0] BUFMODE_BYPASS = 3'h0;
	localparam logic [2:0] BUFMODE_FIFO   = 3'h1;
	localparam logic [2:0] BUFMODE_STREAM = 3'h2;

	// Effective filter path for output data or the interrupt generator
	typedef enum logic [1:0] {
		PATH_RAW      = 2'b00,
		PATH_HP       = 2'b01,
		PATH_LP2      = 2'b10,
		PATH_HP_LP2   = 2'b11
	} gcs_path_t;

	// Register access from the serial front end
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [6:0] addr;
		logic [7:0] wdata;
	} gcs_access_t;

	// Samples from the measurement core
	typedef struct packed {
		logic [2:0]  axis_new;
		logic [15:0] rate_x;
		logic [15:0] rate_y;
		logic [15:0] rate_z;
		logic        temp_new;
		logic [7:0]  temp;
	} gcs_sample_t;

	// One interrupt pin as two signals
	typedef struct packed {
		logic out;
		logic oe;
	} gcs_pin_t;

	// Settings that steer the rest of the device
	typedef struct packed {
		logic [1:0] range_select;
		logic [1:0] selftest_select;
		logic       spi_wire_count_select;
		logic       fifo_on;
		gcs_path_t  output_path;
		gcs_path_t  irq_path;
		logic [7:0] irq_reference_value;
		logic [2:0] buffer_mode;
		logic [4:0] watermark_level;
	} gcs_cfg_t;

endpackage

// ===== rtl/gcs_regs.sv
/*
 * Control and status register bank of a three-axis rate sensor.
 * Serves byte reads and writes from the serial front end, latches samples,
 * keeps ready and overrun flags and drives both interrupt pins.
 * Assumes the front end, the core and the buffer logic share clk; a read
 * answers one cycle after its strobe.
 */

// How it works
// - Routing register enables irq and reload on pin one
// - Polarity bit sets pin one active level
// - Output-type bit picks push-pull or open-drain
// - Four enables route events to pin two
// - Byte-order bit swaps rate byte positions
// - Two-bit field selects full-scale range
// - Two-bit field selects self-test sign
// - Serial mode bit picks four or three wires
// - Reload bit requests trim reload, reads zero
// - Buffer enable bit switches buffer on
// - Output path select with high-pass enable
// - Interrupt path select, same coding
// - Eight-bit reference register feeds interrupt path
// - Per-axis and combined sample ready flags
// - Combined overrun when unread set overwritten
// - Per-axis overrun when unread value overwritten
// - Rates are 16-bit words over byte pairs
// - Three-bit buffer mode field
// - Five-bit watermark level field
// - Reading reference resets high-pass in normal modes
module gcs_regs (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire gcs_pkg::gcs_access_t access,
	input  wire gcs_pkg::gcs_sample_t sample,
	input  wire logic                 irq_event,
	input  wire logic                 reload_busy,
	input  wire logic                 buf_watermark,
	input  wire logic                 buf_overflow,
	input  wire logic                 buf_vacant,
	input  wire logic [1:0]           highpass_mode,
	output logic [7:0]                rd_data,
	output logic                      rd_valid,
	output gcs_pkg::gcs_cfg_t         cfg,
	output logic                      reload_req,
	output logic                      highpass_reset,
	output gcs_pkg::gcs_pin_t         interrupt_pin_one,
	output gcs_pkg::gcs_pin_t         ready_or_interrupt_pin_two
);
	import gcs_pkg::*;

	// Whole state of the bank
	typedef struct packed {
		logic [7:0]  irq_routing;      // Pin routing and drive
		logic [7:0]  range_format;     // Range, order, self-test, wires
		logic [7:0]  filter_fifo;      // Paths, buffer enable
		logic [7:0]  irq_reference;    // Reference byte
		logic [7:0]  temperature;      // Last temperature
		logic [15:0] rate_x;           // Output data registers
		logic [15:0] rate_y;
		logic [15:0] rate_z;
		logic [7:0]  buffer_ctrl;      // Mode and watermark
		logic [2:0]  axis_ready;       // z, y, x
		logic [2:0]  axis_overrun;     // z, y, x
		logic        all_axes_ready;
		logic        all_axes_overrun;
		logic [7:0]  rd_data;
		logic        rd_valid;
		logic        reload_req;
		logic        highpass_reset;
		gcs_pin_t    pin_one;
		gcs_pin_t    pin_two;
	} gcs_state_t;

	gcs_state_t state;       // Registered copy
	gcs_state_t next_state;  // Combinational copy

	// Filter path from a select field and the high-pass enable
	function automatic gcs_path_t gcs_path(input logic [1:0] sel, input logic hp_on);
		gcs_path_t p;
		p = PATH_RAW;
		if (sel[1]) begin
			p = hp_on ? PATH_HP_LP2 : PATH_LP2;
		end else if (sel[0]) begin
			p = PATH_HP;
		end
		return p;
	endfunction

	// Pin drive from an asserted level, polarity and drive type
	function automatic gcs_pin_t gcs_drive(input logic active, input logic act_low,
		input logic open_drain);
		gcs_pin_t pin;
		logic     level;
		level   = active ^ act_low;
		pin.out = level;
		// Open drain only pulls low; high level is left to the pull-up
		pin.oe  = open_drain ? ~level : 1'b1;
		return pin;
	endfunction

	// Byte of a rate word at a pair address, honouring byte order
	function automatic logic [7:0] gcs_pick(input logic [15:0] word, input logic upper,
		input logic msb_first);
		return (upper ^ msb_first) ? word[15:8] : word[7:0];
	endfunction

	// Axis touched by a read address, one bit per axis
	function automatic logic [2:0] gcs_axis_hit(input logic [6:0] addr);
		logic [2:0] hit;
		hit    = 3'h0;
		hit[0] = (addr == ADDR_RATE_X_LOW) || (addr == ADDR_RATE_X_HIGH);
		hit[1] = (addr == ADDR_RATE_Y_LOW) || (addr == ADDR_RATE_Y_HIGH);
		hit[2] = (addr == ADDR_RATE_Z_LOW) || (addr == ADDR_RATE_Z_HIGH);
		return hit;
	endfunction

	// Next state
	always_comb begin
		logic       msb_first;
		logic [2:0] axis_read;
		logic       pin_one_active;
		logic       pin_two_active;
		logic [2:0] axis_clear;
		msb_first      = state.range_format[BIT_BYTE_ORDER];
		axis_read      = access.rd ? gcs_axis_hit(access.addr) : 3'h0;
		pin_one_active = 1'b0;
		pin_two_active = 1'b0;
		axis_clear     = 3'h0;
		next_state     = state;

		// Pulses last one cycle
		next_state.rd_valid       = access.rd;
		next_state.reload_req     = 1'b0;
		next_state.highpass_reset = 1'b0;

		// Register writes, masked so spare bits stay zero
		if (access.wr) begin
			unique case (access.addr)
				ADDR_IRQ_ROUTING: begin
					next_state.irq_routing = access.wdata & MASK_IRQ_ROUTING;
				end
				ADDR_RANGE_FORMAT: begin
					next_state.range_format = access.wdata & MASK_RANGE_FORMAT;
				end
				ADDR_FILTER_FIFO: begin
					// Reload bit is not stored, only requested
					next_state.filter_fifo = access.wdata & MASK_FILTER_FIFO;
					next_state.reload_req  = access.wdata[BIT_RELOAD];
				end
				ADDR_IRQ_REFERENCE: begin
					next_state.irq_reference = access.wdata;
				end
				ADDR_BUFFER_MODE: begin
					next_state.buffer_ctrl = access.wdata & MASK_BUFFER_MODE;
				end
				default: begin
					// Read-only or unmapped: write ignored
				end
			endcase
		end

		// Register reads
		next_state.rd_data = RESET_BYTE;
		if (access.rd) begin
			unique case (access.addr)
				ADDR_IRQ_ROUTING:  next_state.rd_data = state.irq_routing;
				ADDR_RANGE_FORMAT: next_state.rd_data = state.range_format;
				ADDR_FILTER_FIFO:  next_state.rd_data = state.filter_fifo;
				ADDR_IRQ_REFERENCE: begin
					next_state.rd_data = state.irq_reference;
					// Normal high-pass modes have a clear low bit
					next_state.highpass_reset = ~highpass_mode[0];
				end
				ADDR_TEMPERATURE: next_state.rd_data = state.temperature;
				ADDR_SAMPLE_STATUS: begin
					next_state.rd_data = {state.all_axes_overrun, state.axis_overrun,
						state.all_axes_ready, state.axis_ready};
				end
				ADDR_RATE_X_LOW:  next_state.rd_data = gcs_pick(state.rate_x, 1'b0, msb_first);
				ADDR_RATE_X_HIGH: next_state.rd_data = gcs_pick(state.rate_x, 1'b1, msb_first);
				ADDR_RATE_Y_LOW:  next_state.rd_data = gcs_pick(state.rate_y, 1'b0, msb_first);
				ADDR_RATE_Y_HIGH: next_state.rd_data = gcs_pick(state.rate_y, 1'b1, msb_first);
				ADDR_RATE_Z_LOW:  next_state.rd_data = gcs_pick(state.rate_z, 1'b0, msb_first);
				ADDR_RATE_Z_HIGH: next_state.rd_data = gcs_pick(state.rate_z, 1'b1, msb_first);
				ADDR_BUFFER_MODE: next_state.rd_data = state.buffer_ctrl;
				default: begin
					// Unmapped reads return zero
					next_state.rd_data = RESET_BYTE;
				end
			endcase
		end

		// Reading an axis clears its flags; a new sample in the same
		// cycle wins, so no event is lost
		axis_clear = axis_read;

		// Temperature update
		if (sample.temp_new) begin
			next_state.temperature = sample.temp;
		end

		// Latch new rate words
		if (sample.axis_new[0]) begin
			next_state.rate_x = sample.rate_x;
		end
		if (sample.axis_new[1]) begin
			next_state.rate_y = sample.rate_y;
		end
		if (sample.axis_new[2]) begin
			next_state.rate_z = sample.rate_z;
		end

		// Per-axis ready and overrun flags
		for (int i = 0; i < 3; i++) begin
			if (sample.axis_new[i]) begin
				next_state.axis_ready[i] = 1'b1;
				// Unread value overwritten
				if (state.axis_ready[i]) begin
					next_state.axis_overrun[i] = 1'b1;
				end
			end else if (axis_clear[i]) begin
				next_state.axis_ready[i]   = 1'b0;
				next_state.axis_overrun[i] = 1'b0;
			end
		end

		// Combined flags follow the per-axis ones
		next_state.all_axes_ready = &next_state.axis_ready;
		if ((|sample.axis_new) && state.all_axes_ready) begin
			next_state.all_axes_overrun = 1'b1;
		end else if (next_state.axis_overrun == 3'h0) begin
			next_state.all_axes_overrun = 1'b0;
		end

		// Pin one: interrupt generator and reload status
		pin_one_active = (state.irq_routing[BIT_IRQ_TO_PIN_ONE] & irq_event) |
			(state.irq_routing[BIT_RELOAD_TO_PIN_ONE] & reload_busy);
		next_state.pin_one = gcs_drive(pin_one_active,
			state.irq_routing[BIT_PIN_ONE_LOW],
			state.irq_routing[BIT_OPEN_DRAIN]);

		// Pin two: ready and buffer conditions, always active high
		pin_two_active = (state.irq_routing[BIT_READY_TO_TWO] & state.all_axes_ready) |
			(state.irq_routing[BIT_WATERMARK_TO_TWO] & buf_watermark) |
			(state.irq_routing[BIT_OVERFLOW_TO_TWO] & buf_overflow) |
			(state.irq_routing[BIT_VACANT_TO_TWO] & buf_vacant);
		next_state.pin_two = gcs_drive(pin_two_active, 1'b0,
			state.irq_routing[BIT_OPEN_DRAIN]);
	end

	// State register with synchronous reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state                  <= '0;
			state.irq_routing      <= RESET_BYTE;
			state.range_format     <= RESET_BYTE;
			state.filter_fifo      <= RESET_BYTE;
			state.irq_reference    <= RESET_BYTE;
			state.buffer_ctrl      <= RESET_BYTE;
			state.rate_x           <= RESET_WORD;
			state.rate_y           <= RESET_WORD;
			state.rate_z           <= RESET_WORD;
			// Idle push-pull low: inactive for active-high default
			state.pin_one.oe       <= 1'b1;
			state.pin_two.oe       <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from the state flops
	assign rd_data                    = state.rd_data;
	assign rd_valid                   = state.rd_valid;
	assign reload_req                 = state.reload_req;
	assign highpass_reset             = state.highpass_reset;
	assign interrupt_pin_one          = state.pin_one;
	assign ready_or_interrupt_pin_two = state.pin_two;

	// Settings decoded from stored fields only
	assign cfg.range_select          = state.range_format[LSB_RANGE +: 2];
	assign cfg.selftest_select       = state.range_format[LSB_SELFTEST +: 2];
	assign cfg.spi_wire_count_select = state.range_format[BIT_SPI_WIRES];
	assign cfg.fifo_on               = state.filter_fifo[BIT_FIFO_ON];
	assign cfg.output_path           = gcs_path(state.filter_fifo[LSB_OUT_PATH +: 2],
		state.filter_fifo[BIT_HIGHPASS]);
	assign cfg.irq_path              = gcs_path(state.filter_fifo[LSB_IRQ_PATH +: 2],
		state.filter_fifo[BIT_HIGHPASS]);
	assign cfg.irq_reference_value   = state.irq_reference;
	assign cfg.buffer_mode           = state.buffer_ctrl[LSB_BUFFER_MODE +: 3];
	assign cfg.watermark_level       = state.buffer_ctrl[LSB_WATERMARK +: 5];

endmodule

// ===== bench/gcs_regs_asserts.sv
/*
 * Port assertions for the rate sensor register bank.
 * Assumes one clock and a synchronous active-low reset.
 */
module gcs_regs_asserts (
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire gcs_pkg::gcs_access_t access,
	input wire logic                 irq_event,
	input wire logic                 reload_busy,
	input wire logic                 buf_watermark,
	input wire logic                 buf_overflow,
	input wire logic                 buf_vacant,
	input wire logic [1:0]           highpass_mode,
	input wire logic                 rd_valid,
	input wire gcs_pkg::gcs_cfg_t    cfg,
	input wire logic                 reload_req,
	input wire logic                 highpass_reset,
	input wire gcs_pkg::gcs_pin_t    interrupt_pin_one,
	input wire gcs_pkg::gcs_pin_t    ready_or_interrupt_pin_two
);
	timeunit 1ns;
	timeprecision 1ps;
	import gcs_pkg::*;
	logic [7:0] rt; // Routing register shadow
	logic       v1; // Expected pin one level
	logic       v2; // Expected pin two level
	logic       od; // Open-drain drive
	logic       r3; // Ready source on: pin two not predicted
	wire        reload_cause = access.wr && access.addr == ADDR_FILTER_FIFO && access.wdata[BIT_RELOAD];
	wire        hp_cause = access.rd && access.addr == ADDR_IRQ_REFERENCE && !highpass_mode[0];
	// Pins lag their causes by one cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rt <= 8'h00;
			v1 <= 1'b0;
			v2 <= 1'b0;
			od <= 1'b0;
			r3 <= 1'b0;
		end else begin
			if (access.wr && access.addr == ADDR_IRQ_ROUTING) begin
				rt <= access.wdata;
			end
			v1 <= ((rt[7] & irq_event) | (rt[6] & reload_busy)) ^ rt[5];
			v2 <= (rt[2] & buf_watermark) | (rt[1] & buf_overflow) | (rt[0] & buf_vacant);
			od <= rt[4];
			r3 <= rt[3];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_ref_write;
		access.wr && access.addr == ADDR_IRQ_REFERENCE;
	endsequence
	a_read_answer: assert property (access.rd |=> rd_valid)
		else $error("read not answered");
	a_reload_pulse: assert property (reload_cause |=> reload_req)
		else $error("reload not requested");
	a_reload_only: assert property (!reload_cause |=> !reload_req)
		else $error("stray reload request");
	a_hp_reset: assert property (hp_cause |=> highpass_reset)
		else $error("filter reset missing");
	a_hp_only: assert property (!hp_cause |=> !highpass_reset)
		else $error("stray filter reset");
	a_ref_value: assert property (s_ref_write |=> cfg.irq_reference_value == $past(access.wdata))
		else $error("reference not stored");
	// Open drain only ever drives low; push-pull always drives the level
	a_pin_one: assert property (
		od ? (interrupt_pin_one.oe == !v1 && !(interrupt_pin_one.oe && interrupt_pin_one.out))
			: (interrupt_pin_one.oe && interrupt_pin_one.out == v1))
		else $error("pin one wrong");
	a_pin_two: assert property (!r3 |-> (
		od ? (ready_or_interrupt_pin_two.oe == !v2 &&
			!(ready_or_interrupt_pin_two.oe && ready_or_interrupt_pin_two.out))
			: (ready_or_interrupt_pin_two.oe && ready_or_interrupt_pin_two.out == v2)))
		else $error("pin two wrong");
endmodule
bind gcs_regs gcs_regs_asserts u_chk (
	.clk                        (clk),
	.rst_n                      (rst_n),
	.access                     (access),
	.irq_event                  (irq_event),
	.reload_busy                (reload_busy),
	.buf_watermark              (buf_watermark),
	.buf_overflow               (buf_overflow),
	.buf_vacant                 (buf_vacant),
	.highpass_mode              (highpass_mode),
	.rd_valid                   (rd_valid),
	.cfg                        (cfg),
	.reload_req                 (reload_req),
	.highpass_reset             (highpass_reset),
	.interrupt_pin_one          (interrupt_pin_one),
	.ready_or_interrupt_pin_two (ready_or_interrupt_pin_two)
);

// ===== bench/gcs_core_model.sv
/*
 * Measurement core stand-in feeding samples to the register bank.
 * Assumes the bank takes samples on the rising clock edge.
 */
module gcs_core_model (
	input  wire logic          clk,
	output gcs_pkg::gcs_sample_t sample
);
	timeunit 1ns;
	timeprecision 1ps;
	import gcs_pkg::*;
	initial sample = '0;
	// One sample set, new flags pulse for one cycle
	task automatic push(input logic [2:0] ax, input logic [15:0] x, y, z, input logic [7:0] t);
		@(posedge clk);
		sample <= '{axis_new: ax, rate_x: x, rate_y: y, rate_z: z, temp_new: 1'b1, temp: t};
		@(posedge clk);
		sample.axis_new <= 3'h0;
		sample.temp_new <= 1'b0;
	endtask
endmodule

// ===== bench/testbench.sv
/*
 * Self-checking bench for the register bank: access, decode, flags, pins.
 * Assumes the core model and the bank share the bench clock.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import gcs_pkg::*;
	logic        clk;
	logic        rst_n;
	gcs_access_t access;
	gcs_sample_t sample;
	logic        irq_event, reload_busy, buf_watermark, buf_overflow, buf_vacant;
	logic [1:0]  highpass_mode;
	logic [7:0]  rd_data, exp;
	logic        rd_valid, reload_req, highpass_reset, hp_seen;
	gcs_cfg_t    cfg;
	gcs_pin_t    pin_one, pin_two;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	// Routing byte, inputs {irq,busy,wm,ovf,vac}, expected {wire1,oe1,wire2,oe2}
	logic [16:0] pin_tbl [9] = '{{8'h80, 5'h10, 4'hD}, {8'hA0, 5'h10, 4'h5}, {8'hB0, 5'h00, 4'h9},
		{8'h40, 5'h08, 4'hD}, {8'h04, 5'h04, 4'h7}, {8'h02, 5'h02, 4'h7}, {8'h01, 5'h01, 4'h7},
		{8'h07, 5'h00, 4'h5}, {8'h1F, 5'h04, 4'h6}};
	gcs_regs dut (.clk(clk), .rst_n(rst_n), .access(access), .sample(sample), .irq_event(irq_event),
		.reload_busy(reload_busy), .buf_watermark(buf_watermark), .buf_overflow(buf_overflow),
		.buf_vacant(buf_vacant), .highpass_mode(highpass_mode), .rd_data(rd_data), .rd_valid(rd_valid),
		.cfg(cfg), .reload_req(reload_req), .highpass_reset(highpass_reset),
		.interrupt_pin_one(pin_one), .ready_or_interrupt_pin_two(pin_two));
	gcs_core_model core (.clk(clk), .sample(sample));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			stop_test();
		end
	end
	// Pin seen on a wire with pull-up
	function automatic logic wire_of(input gcs_pin_t p);
		return p.oe ? p.out : 1'b1;
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask
	// Strobes last exactly one cycle
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		access <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge clk);
		access <= '0;
		#1;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] want);
		@(posedge clk);
		access <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk);
		access <= '0;
		#1;
		hp_seen = highpass_reset;
		check("read valid", {7'h0, rd_valid}, 8'h01);
		check("read data", rd_data, want);
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		access = '0;
		{irq_event, reload_busy, buf_watermark, buf_overflow, buf_vacant} = 5'h00;
		highpass_mode = 2'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Whole bank starts cleared
		for (int a = 'h22; a <= 'h2E; a++) begin
			rd(7'(a), 8'h00);
		end
		wr(ADDR_IRQ_ROUTING, 8'hFF);
		rd(ADDR_IRQ_ROUTING, 8'hFF);
		wr(ADDR_RANGE_FORMAT, 8'hFF);
		rd(ADDR_RANGE_FORMAT, 8'h77);
		check("wires", {7'h0, cfg.spi_wire_count_select}, 8'h01);
		wr(ADDR_FILTER_FIFO, 8'hFF);
		rd(ADDR_FILTER_FIFO, 8'h5F);
		check("buffer on", {7'h0, cfg.fifo_on}, 8'h01);
		wr(ADDR_TEMPERATURE, 8'hFF);
		rd(ADDR_TEMPERATURE, 8'h00);
		// Every range and self-test code
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_RANGE_FORMAT, 8'(i * 'h12));
			check("range", {6'h0, cfg.range_select}, 8'(i));
			check("selftest", {6'h0, cfg.selftest_select}, 8'(i));
		end
		// Path codes with high-pass off and on
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_FILTER_FIFO, 8'(((k & 4) << 2) | ((k & 3) * 5)));
			exp = (k & 2) ? 8'(2 + ((k >> 2) & 1)) : 8'(k & 1);
			check("output path", {6'h0, cfg.output_path}, exp);
			check("irq path", {6'h0, cfg.irq_path}, exp);
		end
		for (int m = 0; m < 3; m++) begin
			wr(ADDR_BUFFER_MODE, 8'(m * 32 + 31 - m));
			check("buffer mode", {5'h0, cfg.buffer_mode}, 8'(m));
			check("watermark", {3'h0, cfg.watermark_level}, 8'(31 - m));
		end
		wr(ADDR_IRQ_REFERENCE, 8'hA5);
		check("reference", cfg.irq_reference_value, 8'hA5);
		// Reference read resets the filter only in normal modes
		for (int h = 0; h < 4; h++) begin
			@(posedge clk);
			highpass_mode <= 2'(h);
			rd(ADDR_IRQ_REFERENCE, 8'hA5);
			check("filter reset", {7'h0, hp_seen}, 8'(~h & 1));
		end
		wr(ADDR_RANGE_FORMAT, 8'h00);
		core.push(3'h7, 16'h8123, 16'h7F01, 16'hFFFE, 8'h3C);
		rd(ADDR_SAMPLE_STATUS, 8'h0F);
		core.push(3'h1, 16'h8124, 16'h7F01, 16'hFFFE, 8'h3C);
		rd(ADDR_SAMPLE_STATUS, 8'h9F);
		rd(ADDR_RATE_X_LOW, 8'h24);
		rd(ADDR_RATE_X_HIGH, 8'h81);
		rd(ADDR_SAMPLE_STATUS, 8'h06);
		wr(ADDR_RANGE_FORMAT, 8'h40);
		rd(ADDR_RATE_Y_LOW, 8'h7F);
		rd(ADDR_RATE_Z_HIGH, 8'hFE);
		rd(ADDR_TEMPERATURE, 8'h3C);
		rd(ADDR_SAMPLE_STATUS, 8'h00);
		// Pin routing, polarity and drive cases
		foreach (pin_tbl[j]) begin
			@(posedge clk);
			{irq_event, reload_busy, buf_watermark, buf_overflow, buf_vacant} <= pin_tbl[j][8:4];
			wr(ADDR_IRQ_ROUTING, pin_tbl[j][16:9]);
			repeat (2) @(posedge clk);
			#1;
			check("pins", {4'h0, wire_of(pin_one), pin_one.oe, wire_of(pin_two), pin_two.oe},
				{4'h0, pin_tbl[j][3:0]});
		end
		core.push(3'h7, 16'h0001, 16'h0002, 16'h0003, 8'h00);
		wr(ADDR_IRQ_ROUTING, 8'h08);
		repeat (2) @(posedge clk);
		#1;
		check("ready pin", {7'h0, pin_two.out}, 8'h01);
		// Reset in mid-run must clear settings, flags and words again
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(ADDR_IRQ_ROUTING, 8'h00);
		rd(ADDR_SAMPLE_STATUS, 8'h00);
		rd(ADDR_RATE_Y_LOW, 8'h00);
		check("reset pin", {6'h0, pin_two.out, pin_two.oe}, 8'h01);
		stop_test();
	end
endmodule
